/* include/host_port_defines.vh */
`ifndef HOST_PORT_DEFINES_VH
`define HOST_PORT_DEFINES_VH

// Width of the shared bus and of the direct address inputs.
`define DATA_W 8
`define ADDR_W 6

// Size of the register window behind the port.
`define REG_DEPTH 64

// Clock rate in kHz and the least reset pulse time in microseconds.
`define CLK_KHZ 40000
`define RST_MIN_US 4000

// Least reset pulse in clock cycles, rounded up.
`define RST_MIN_CYC ((`RST_MIN_US * `CLK_KHZ + 999) / 1000)

// Reset pulse length that the device drives out when it resets itself.
`define RST_OUT_CYC 8'h10

// Mode selection values.
`define MODE_MUX 1'b1
`define STRB_COMBINED 1'b1

`endif

/* rtl/host_parallel_bus_port.v */
// Behaviour
// - Eight-bit host data path, multiplexed or non-multiplexed addressing supported.
// - Multiplexed: shared lines carry address first, then data either way.
// - Non-multiplexed: shared lines carry data; address on six direct inputs.
// - Combined strobe mode: rising edge of access strobe ends the access.
// - Interrupt output is open drain: pulled active, otherwise undriven.
// - Latch enable level selects multiplexed or non-multiplexed operation.
// - High reset pin forces reset; pulse lasts at least four milliseconds.
// - With terminal functions enabled, device may drive reset pin itself.
`timescale 1ns/1ps
`include "host_port_defines.vh"

module host_parallel_bus_port #(
  parameter RST_MIN_CYC = `RST_MIN_CYC
) (
  input  wire                 mclk_i,
  input  wire                 rst_n_i,
  input  wire [`DATA_W-1:0]   shared_bus_i,
  output reg  [`DATA_W-1:0]   shared_bus_o,
  output wire                 shared_bus_oe_n_o,
  input  wire [`ADDR_W-1:0]   direct_addr_i,
  input  wire                 chip_sel_n_i,
  input  wire                 rw_wr_n_i,
  input  wire                 access_strobe_rd_n_i,
  input  wire                 addr_latch_en_i,
  input  wire                 strobe_style_i,
  input  wire                 term_func_en_i,
  input  wire                 wake_req_i,
  input  wire                 irq_req_i,
  output wire                 irq_o,
  output wire                 irq_oe_n_o,
  input  wire                 reset_pin_i,
  output wire                 reset_pin_o,
  output wire                 reset_pin_oe_n_o,
  output reg                  dev_reset_o,
  output reg                  wr_stb_o,
  output reg  [`ADDR_W-1:0]   reg_addr_o,
  output reg  [`DATA_W-1:0]   wr_data_o,
  output reg                  rd_stb_o
);

  // One-hot sequencer states: waiting, inside an access, and one settling cycle after it.
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ACC  = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  // Sequencer, latched address, strobe and wake history, reset timers and the window.
  // The window sits in flip-flops so every byte can be cleared in one reset cycle.
  reg [2:0]          state_q;
  reg [`ADDR_W-1:0]  addr_q;
  reg                is_read_q;
  reg                strb_prev_q;
  reg [31:0]         rst_cnt_q;
  reg [7:0]          out_cnt_q;
  reg                wake_prev_q;
  reg [`DATA_W-1:0]  regs_q [0:`REG_DEPTH-1];

  // Both mode pins are read as static levels; changing them mid-access is not supported.
  // The latch enable pin doubles as the addressing mode select.
  wire mux_mode = (addr_latch_en_i == `MODE_MUX);
  wire combined = (strobe_style_i == `STRB_COMBINED);

  // Active access request in the selected strobe style, read or write.
  function active_req;
    input comb;
    input rw;
    input ds;
    begin
      if (comb) begin
        active_req = ~ds;
      end else begin
        active_req = ~rw | ~ds;
      end
    end
  endfunction

  // Register index of an access: latched address when multiplexed, else direct inputs.
  function [`ADDR_W-1:0] pick_addr;
    input               mux;
    input [`ADDR_W-1:0] latched;
    input [`ADDR_W-1:0] direct;
    begin
      pick_addr = mux ? latched : direct;
    end
  endfunction

  // Request decode; the strobe edge detector compares with the level seen at the last edge.
  wire [`ADDR_W-1:0] acc_addr = pick_addr(mux_mode, addr_q, direct_addr_i);
  wire req = ~chip_sel_n_i & active_req(combined, rw_wr_n_i, access_strobe_rd_n_i);
  wire req_read = combined ? rw_wr_n_i : ~access_strobe_rd_n_i;
  wire strb_rise = access_strobe_rd_n_i & ~strb_prev_q;

  // Latch enable level picks the addressing style; a static high means multiplexed.
  // The address is latched while latch enable is high, before the strobe arrives.
  // A host that only pulses latch enable would also flip the mode, so it must hold it high.
  // Latching stops once a strobe is seen, so data on the same lines never overwrites it.
  always @(posedge mclk_i) begin
    if (!rst_n_i || dev_reset_o) begin
      addr_q <= 6'h00;
    end else if (mux_mode && chip_sel_n_i == 1'b0 && state_q == ST_IDLE && !req) begin
      addr_q <= shared_bus_i[`ADDR_W-1:0];
    end
  end

  // Access sequencer: the request opens the access and the strobe release ends it.
  // Read data is fetched at the opening edge, so it stands well before the host samples it.
  always @(posedge mclk_i) begin
    if (!rst_n_i || dev_reset_o) begin
      state_q     <= ST_IDLE;
      is_read_q   <= 1'b0;
      strb_prev_q <= 1'b1;
      wr_stb_o    <= 1'b0;
      rd_stb_o    <= 1'b0;
      reg_addr_o  <= 6'h00;
      wr_data_o   <= 8'h00;
      shared_bus_o <= 8'h00;
    end else begin
      strb_prev_q <= access_strobe_rd_n_i;
      wr_stb_o    <= 1'b0;
      rd_stb_o    <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (req) begin
            is_read_q  <= req_read;
            reg_addr_o <= acc_addr;
            shared_bus_o <= regs_q[acc_addr];
            rd_stb_o   <= req_read;
            state_q    <= ST_ACC;
          end
        end
        ST_ACC: begin
          if (!active_req(combined, rw_wr_n_i, access_strobe_rd_n_i) || chip_sel_n_i) begin
            // Write data is taken at the end of the strobe, when it is surely stable.
            // A combined write cut short by select going high is not stored.
            if (!is_read_q && (!combined || strb_rise)) begin
              wr_stb_o  <= 1'b1;
              wr_data_o <= shared_bus_i;
            end
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          // One quiet cycle keeps a slow strobe release from opening a second access.
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Register window storage, loaded by host writes.
  // The index is widened to the loop counter's width so no bits are dropped in the compare.
  genvar gi;
  generate
    for (gi = 0; gi < `REG_DEPTH; gi = gi + 1) begin : g_regs
      always @(posedge mclk_i) begin
        if (!rst_n_i || dev_reset_o) begin
          regs_q[gi] <= 8'h00;
        end else if (wr_stb_o && {{(32-`ADDR_W){1'b0}}, reg_addr_o} == gi) begin
          regs_q[gi] <= wr_data_o;
        end
      end
    end
  endgenerate

  // Read data is driven only during a selected read access.
  // The enable is combinational so the lines are freed in the cycle the access closes.
  assign shared_bus_oe_n_o = ~(state_q == ST_ACC && is_read_q && !chip_sel_n_i);

  // Open drain interrupt: only ever pulls low, released otherwise.
  // The line is never driven high; an outside pull-up restores the idle level.
  assign irq_o      = 1'b0;
  assign irq_oe_n_o = ~irq_req_i;

  // A reset pin high for the least pulse time puts the port into reset.
  // Shorter glitches are filtered so a noisy pin cannot wipe the registers.
  // The counter stops one short of the limit, so a long pulse never wraps it.
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rst_cnt_q   <= 32'h0;
      dev_reset_o <= 1'b0;
    end else if (reset_pin_i) begin
      if (rst_cnt_q >= RST_MIN_CYC - 1) begin
        dev_reset_o <= 1'b1;
      end else begin
        rst_cnt_q <= rst_cnt_q + 32'h1;
      end
    end else begin
      rst_cnt_q   <= 32'h0;
      dev_reset_o <= 1'b0;
    end
  end

  // Wake request falling edge issues a reset pulse out when enabled.
  // A new falling edge while a pulse runs restarts it at full length.
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wake_prev_q <= 1'b1;
      out_cnt_q   <= 8'h00;
    end else begin
      wake_prev_q <= wake_req_i;
      if (term_func_en_i && wake_prev_q && !wake_req_i) begin
        out_cnt_q <= `RST_OUT_CYC;
      end else if (out_cnt_q != 8'h00) begin
        out_cnt_q <= out_cnt_q - 8'h01;
      end
    end
  end

  // The reset pin is driven high only while the pulse counter runs, otherwise left free.
  // That pulse also reaches this port's own reset filter through the pin.
  assign reset_pin_o      = 1'b1;
  assign reset_pin_oe_n_o = ~(out_cnt_q != 8'h00);

endmodule // host_parallel_bus_port

/* verif/port_checker_sva.sv */
`timescale 1ns/1ps
module port_checker #(parameter RST_MIN_CYC = 8) (
  input wire mclk_i, rst_n_i, chip_sel_n_i, rw_wr_n_i, access_strobe_rd_n_i,
  input wire addr_latch_en_i, strobe_style_i, term_func_en_i, wake_req_i, irq_req_i,
  input wire irq_o, irq_oe_n_o, reset_pin_i, reset_pin_o, reset_pin_oe_n_o,
  input wire shared_bus_oe_n_o, dev_reset_o, wr_stb_o, rd_stb_o,
  input wire [7:0] shared_bus_i, wr_data_o,
  input wire [5:0] direct_addr_i, reg_addr_o
);
  // Everything is judged on the port clock and masked only while rst_n_i is low, not during dev_reset_o.
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire sel = !chip_sel_n_i;
  irq_drain_a: assert property (irq_o == 1'b0 && irq_oe_n_o == !irq_req_i)
    else $error("irq pin");
  wr_commit_a: assert property ($rose(access_strobe_rd_n_i) && sel && strobe_style_i &&
    !rw_wr_n_i |=> wr_stb_o && wr_data_o == $past(shared_bus_i)) else $error("write lost");
  rd_start_a: assert property ($fell(access_strobe_rd_n_i) && sel && strobe_style_i &&
    rw_wr_n_i |=> rd_stb_o) else $error("read lost");
  direct_addr_a: assert property ($fell(access_strobe_rd_n_i) && sel && !addr_latch_en_i
    |=> reg_addr_o == $past(direct_addr_i)) else $error("direct addr");
  mux_addr_a: assert property ($fell(access_strobe_rd_n_i) && sel && addr_latch_en_i
    |=> reg_addr_o == $past(shared_bus_i[5:0], 2)) else $error("mux addr");
  bus_drive_a: assert property (!shared_bus_oe_n_o |-> sel && rw_wr_n_i)
    else $error("bus driven");
  // Counts edges with the reset pin high, saturating at the filter length.
  reg [31:0] pin_hi_q;
  always @(posedge mclk_i) begin
    if (!rst_n_i || !reset_pin_i) pin_hi_q <= 32'h0;
    else if (pin_hi_q < RST_MIN_CYC) pin_hi_q <= pin_hi_q + 32'h1;
  end
  reset_hold_a: assert property (dev_reset_o == (pin_hi_q >= RST_MIN_CYC))
    else $error("reset filter");
  self_reset_a: assert property (term_func_en_i && $fell(wake_req_i) |-> ##[1:3]
    (!reset_pin_oe_n_o && reset_pin_o)) else $error("no self reset");
endmodule // port_checker
bind host_parallel_bus_port port_checker #(.RST_MIN_CYC(RST_MIN_CYC)) port_checker_i (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .chip_sel_n_i(chip_sel_n_i), .rw_wr_n_i(rw_wr_n_i),
  .access_strobe_rd_n_i(access_strobe_rd_n_i), .addr_latch_en_i(addr_latch_en_i),
  .strobe_style_i(strobe_style_i), .term_func_en_i(term_func_en_i),
  .wake_req_i(wake_req_i), .irq_req_i(irq_req_i), .irq_o(irq_o), .irq_oe_n_o(irq_oe_n_o),
  .reset_pin_i(reset_pin_i), .reset_pin_o(reset_pin_o), .reset_pin_oe_n_o(reset_pin_oe_n_o),
  .shared_bus_oe_n_o(shared_bus_oe_n_o), .dev_reset_o(dev_reset_o), .wr_stb_o(wr_stb_o),
  .rd_stb_o(rd_stb_o), .shared_bus_i(shared_bus_i), .wr_data_o(wr_data_o),
  .direct_addr_i(direct_addr_i), .reg_addr_o(reg_addr_o));

/* verif/host_cpu_model.sv */
`timescale 1ns/1ps
module host_cpu_model (
  input  wire       mclk_i,
  input  wire [7:0] bus_i,
  output reg  [7:0] bus_o,
  output reg  [5:0] addr_o,
  output reg        cs_n_o, rw_o, stb_o, ale_o, sty_o
);
  initial {bus_o, addr_o, cs_n_o, rw_o, stb_o, ale_o, sty_o} = {14'h0, 5'b11110};
  // One byte access. A released bus shows the inverted last value, so a non-multiplexed read after a write sees the byte just written.
  task acc(input m, s, r, input [5:0] a, input [7:0] d, output [7:0] q);
    begin
      cs_n_o = 0;
      ale_o = m;
      sty_o = s;
      rw_o = s ? r : 1'b1;
      addr_o = m ? ~a : a; // Multiplexed accesses put junk on the direct lines.
      bus_o = m ? {2'h0, a} : (r ? ~bus_o : d);
      @(posedge mclk_i) #2;
      if (m) bus_o = r ? ~bus_o : d;
      if (s || r) stb_o = 0;
      else rw_o = 0;
      repeat (2) @(posedge mclk_i);
      #2 q = bus_i;
      stb_o = 1;
      rw_o = s ? r : 1'b1;
      @(posedge mclk_i) #2 cs_n_o = 1;
      bus_o = ~bus_o;
      repeat (2) @(posedge mclk_i);
      #2;
    end
  endtask
endmodule // host_cpu_model

/* verif/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED %0t value mismatch", $time); end end
module testbench;
  reg mclk_i = 0, rst_n_i = 0, term_en = 0, wake = 1, irq_req = 0, rst_drv = 0;
  integer seed = 60867, failures = 0, num_checks = 0, k;
  reg [7:0] q, d;
  reg [5:0] a;
  wire [7:0] hbus, dbus;
  wire [5:0] haddr;
  wire hcs, hrw, hstb, hale, hsty, oe_n, irq, irq_oe_n, rp_o, rp_oe_n, dev_rst, ws, rs;
  wire [5:0] ra;
  wire [7:0] wd;
  integer nwr = 0, nrd = 0;
  // Shared lines resolve to whichever side drives them; reset pin falls back to the bench.
  wire [7:0] bus = oe_n ? hbus : dbus;
  wire rpin = rp_oe_n ? rst_drv : rp_o;
  initial forever #12.5 mclk_i = ~mclk_i;
  host_cpu_model host_cpu_model_i (.mclk_i(mclk_i), .bus_i(bus), .bus_o(hbus), .addr_o(haddr),
    .cs_n_o(hcs), .rw_o(hrw), .stb_o(hstb), .ale_o(hale), .sty_o(hsty));
  host_parallel_bus_port #(.RST_MIN_CYC(8)) host_parallel_bus_port_i (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .shared_bus_i(bus), .shared_bus_o(dbus), .shared_bus_oe_n_o(oe_n),
    .direct_addr_i(haddr), .chip_sel_n_i(hcs), .rw_wr_n_i(hrw), .access_strobe_rd_n_i(hstb),
    .addr_latch_en_i(hale), .strobe_style_i(hsty), .term_func_en_i(term_en),
    .wake_req_i(wake), .irq_req_i(irq_req), .irq_o(irq), .irq_oe_n_o(irq_oe_n),
    .reset_pin_i(rpin), .reset_pin_o(rp_o), .reset_pin_oe_n_o(rp_oe_n), .dev_reset_o(dev_rst),
    .wr_stb_o(ws), .reg_addr_o(ra), .wr_data_o(wd), .rd_stb_o(rs));
  // Strobe pulses last one clock, so the falling edge sees each exactly once.
  always @(negedge mclk_i) begin
    if (rst_n_i) begin
      nwr = nwr + ws;
      nrd = nrd + rs;
    end
  end
  // Open-drain request: the enable is low exactly while a request is pending.
  function exp_irq_oe_n(input req);
    exp_irq_oe_n = !req;
  endfunction
  task end_sim;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // A hung run is cut short and counted as a mismatch.
  initial begin
    #1000000 failures++;
    end_sim;
  end
  // Writes in one random mode are read back in a separately drawn random mode, so both address paths must agree.
  initial begin
    repeat (5) @(posedge mclk_i);
    #2 rst_n_i = 1;
    for (k = 0; k < 24; k++) begin
      a = (k == 0) ? 6'h3f : 6'($random(seed));
      d = (k == 0) ? 8'hff : 8'($random(seed));
      irq_req = 1'($random(seed));
      host_cpu_model_i.acc(1'($random(seed)), 1'($random(seed)), 1'b0, a, d, q);
      `CHK(wd, d)
      `CHK(ra, a)
      host_cpu_model_i.acc(1'($random(seed)), 1'($random(seed)), 1'b1, a, 8'h00, q);
      `CHK(q, d)
      `CHK(ra, a)
      `CHK(irq_oe_n, exp_irq_oe_n(irq_req))
      `CHK(irq, 1'b0)
    end
    `CHK(nwr, 32'h18)
    `CHK(nrd, 32'h18)
    rst_drv = 1;
    repeat (3) @(posedge mclk_i);
    #2 `CHK(dev_rst, 1'b0)
    repeat (10) @(posedge mclk_i);
    #2 `CHK(dev_rst, 1'b1)
    rst_drv = 0;
    @(posedge mclk_i) #2 wake = 0;
    repeat (3) @(posedge mclk_i);
    #2 `CHK(rp_oe_n, 1'b1)
    wake = 1;
    term_en = 1;
    @(posedge mclk_i) #2 wake = 0;
    for (k = 0; k < 8 && rp_oe_n; k++) @(posedge mclk_i);
    #2 `CHK(rpin, 1'b1)
    end_sim;
  end
endmodule // testbench
